/* rtl/ascs_map.svh */
`ifndef ASCS_MAP_SVH
`define ASCS_MAP_SVH
// register word indices
`define ASCS_OFS_CTRL_A   4'h0
`define ASCS_OFS_CTRL_B   4'h1
`define ASCS_OFS_CTRL_C   4'h2
`define ASCS_OFS_STATUS_A 4'h3
`define ASCS_OFS_DATA     4'h4
`define ASCS_OFS_BAUD     4'h5
// control a fields
`define ASCS_A_MODULE_EN  7
`define ASCS_A_NINE_BIT   4
`define ASCS_A_WAKE_ADDR  3
// control b fields
`define ASCS_B_TXE_IE     7
`define ASCS_B_TXD_IE     6
`define ASCS_B_RXF_IE     5
`define ASCS_B_IDLE_IE    4
`define ASCS_B_TX_EN      3
`define ASCS_B_RX_EN      2
`define ASCS_B_STANDBY    1
`define ASCS_B_BREAK      0
// control c fields
`define ASCS_C_RX9        7
`define ASCS_C_TX9        6
`define ASCS_C_OR_IE      3
`define ASCS_C_NE_IE      2
`define ASCS_C_FE_IE      1
`define ASCS_C_PE_IE      0
// status a fields
`define ASCS_S_TXE        7
`define ASCS_S_TXD        6
`define ASCS_S_RXF        5
`define ASCS_S_IDLE       4
`define ASCS_S_OVR        3
`define ASCS_S_NF         2
`define ASCS_S_FE         1
`define ASCS_S_PE         0
// reset values
`define ASCS_RST_STATUS   8'hC0
`define ASCS_RST_BAUD     16'h0010
// timing
`define ASCS_RX_SAMPLES   4'h8
`endif

/* rtl/ascs_pkg.sv */
package ascs_pkg;
	typedef enum logic [3:0] {
		TX_IDLE  = 4'b0001,
		TX_PRE   = 4'b0010,
		TX_BRK   = 4'b0100,
		TX_DATA  = 4'b1000
	} ascs_tx_t;
	typedef struct packed {
		logic txReq;
		logic rxReq;
		logic errReq;
	} ascs_irq_t;
endpackage

/* rtl/ascs_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ascs_map.svh"
module ascs_core
	import ascs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        clkEn,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	output var  logic        txLine,
	input  wire logic        rxLine,
	output var  logic        txIrq,
	output var  logic        rxIrq,
	output var  logic        errIrq
);
	logic        rsMeta, rs;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rsMeta <= 1'b0;
			rs     <= 1'b0;
		end else begin
			rsMeta <= 1'b1;
			rs     <= rsMeta;
		end
	end

	logic [7:0]  ctrlA_reg, ctrlB_reg, ctrlC_reg, status_reg, rxData_reg, txData_reg;
	logic [15:0] baud_reg;
	logic        rx9_reg, ack_reg, pendLoad_reg, queueIdle_reg, seenOvr_reg;
	logic        seenRxf_reg, seenTxe_reg, seenIdle_reg, idleArm_reg, brkHold_reg;
	ascs_tx_t    txState_reg;
	logic [15:0] txDiv_reg;
	logic [3:0]  txBit_reg;
	logic [10:0] txShift_reg;
	logic        txLine_reg;
	ascs_irq_t   irq_next;

	wire acc     = clkEn && (read || write) && !ack_reg;
	wire wr      = acc && write;
	wire rd      = acc && read;
	wire modEn   = ctrlA_reg[`ASCS_A_MODULE_EN];
	wire nine    = ctrlA_reg[`ASCS_A_NINE_BIT];
	wire [3:0] charLen = nine ? 4'hB : 4'hA;
	wire wrData  = wr && address == `ASCS_OFS_DATA;
	wire rdData  = rd && address == `ASCS_OFS_DATA;
	wire rdStat  = rd && address == `ASCS_OFS_STATUS_A;
	wire txBusy  = txState_reg != TX_IDLE;

	// bus: one wait cycle, then ack; waitrequest is its own flop, not an inverter
	always_ff @(posedge clock or negedge rs) begin
		if (!rs) begin
			ack_reg     <= 1'b0;
			waitrequest <= 1'b1;
		end else if (clkEn) begin
			ack_reg     <= (read || write) && !ack_reg;
			waitrequest <= !((read || write) && !ack_reg);
		end
	end

	always_ff @(posedge clock or negedge rs) begin
		if (!rs) readdata <= 32'h0000_0000;
		else if (rd) begin
			unique case (address)
			`ASCS_OFS_CTRL_A:   readdata <= {24'h00_0000, ctrlA_reg};
			`ASCS_OFS_CTRL_B:   readdata <= {24'h00_0000, ctrlB_reg};
			`ASCS_OFS_CTRL_C:   readdata <= {24'h00_0000, rx9_reg, ctrlC_reg[6:0]};
			`ASCS_OFS_STATUS_A: readdata <= {24'h00_0000, status_reg};
			`ASCS_OFS_DATA:     readdata <= {24'h00_0000, rxData_reg};
			`ASCS_OFS_BAUD:     readdata <= {16'h0000, baud_reg};
			default:            readdata <= 32'h0000_0000;
			endcase
		end
	end

	// control registers
	logic txRise;
	always_ff @(posedge clock or negedge rs) begin
		if (!rs) begin
			ctrlA_reg <= 8'h00;
			ctrlC_reg <= 8'h00;
			baud_reg  <= `ASCS_RST_BAUD;
		end else if (clkEn && wr) begin
			if (address == `ASCS_OFS_CTRL_A) ctrlA_reg <= writedata[7:0];
			if (address == `ASCS_OFS_CTRL_C) ctrlC_reg <= {1'b0, writedata[6:0]};
			if (address == `ASCS_OFS_BAUD && writedata[15:0] != 16'h0000)
				baud_reg <= writedata[15:0];
		end
	end

	wire wakeHit;
	always_ff @(posedge clock or negedge rs) begin
		if (!rs) ctrlB_reg <= 8'h00;
		else if (clkEn) begin
			if (wr && address == `ASCS_OFS_CTRL_B) begin
				ctrlB_reg[7:4] <= writedata[7:4];
				ctrlB_reg[1:0] <= writedata[1:0];
				if (modEn) ctrlB_reg[3:2] <= writedata[3:2];
			end
			if (wakeHit) ctrlB_reg[`ASCS_B_STANDBY] <= 1'b0;
		end
	end
	assign txRise = wr && address == `ASCS_OFS_CTRL_B && modEn &&
		writedata[3] && !ctrlB_reg[3];

	// transmitter
	wire txTick = txDiv_reg == 16'h0000;
	wire brkCtl = ctrlB_reg[`ASCS_B_BREAK];
	logic preReq_reg;
	always_ff @(posedge clock or negedge rs) begin
		if (!rs) begin
			txState_reg   <= TX_IDLE;
			txData_reg    <= 8'h00;
			txDiv_reg     <= 16'h0000;
			txBit_reg     <= 4'h0;
			txShift_reg   <= 11'h7FF;
			txLine_reg    <= 1'b1;
			preReq_reg    <= 1'b0;
			queueIdle_reg <= 1'b0;
			brkHold_reg   <= 1'b0;
			pendLoad_reg  <= 1'b0;
		end else if (clkEn) begin
			if (txRise) preReq_reg <= 1'b1;
			if (txRise && txBusy) queueIdle_reg <= 1'b1;
			if (wrData) begin
				txData_reg   <= writedata[7:0];
				pendLoad_reg <= 1'b1;
			end
			if (brkCtl) brkHold_reg <= 1'b1;
			// reload one short so a bit lasts exactly baud_reg clocks
			txDiv_reg <= txTick ? baud_reg - 16'h0001 : txDiv_reg - 16'h0001;
			if (!modEn) begin
				txState_reg <= TX_IDLE;
				txLine_reg  <= 1'b1;
				preReq_reg  <= 1'b0;
			end else if (txTick) begin
				unique case (txState_reg)
				TX_IDLE: begin
					txLine_reg <= 1'b1;
					if (brkHold_reg || brkCtl) begin
						// break beats a not yet started preamble
						txState_reg <= TX_BRK;
						preReq_reg  <= 1'b0;
						brkHold_reg <= 1'b0;
						txBit_reg   <= charLen;
					end else if ((preReq_reg || queueIdle_reg) && ctrlB_reg[3]) begin
						txState_reg   <= TX_PRE;
						preReq_reg    <= 1'b0;
						queueIdle_reg <= 1'b0;
						txBit_reg     <= charLen;
					end else if (pendLoad_reg && ctrlB_reg[3]) begin
						txState_reg  <= TX_DATA;
						pendLoad_reg <= 1'b0;
						// 8-bit frames put the stop bit where the ninth bit would go
						txShift_reg  <= nine ? {1'b1, ctrlC_reg[`ASCS_C_TX9], txData_reg, 1'b0}
							: {2'b11, txData_reg, 1'b0};
						txBit_reg    <= charLen;
					end
				end
				TX_PRE: begin
					txLine_reg <= 1'b1;
					txBit_reg  <= txBit_reg - 4'h1;
					if (txBit_reg == 4'h1) txState_reg <= TX_IDLE;
				end
				TX_BRK: begin
					txLine_reg <= 1'b0;
					txBit_reg  <= txBit_reg - 4'h1;
					if (txBit_reg == 4'h1) begin
						// held control repeats with no high gap
						if (brkCtl) txBit_reg <= charLen;
						else txState_reg <= TX_IDLE;
					end
				end
				TX_DATA: begin
					txLine_reg  <= txShift_reg[0];
					txShift_reg <= nine ? {1'b1, txShift_reg[10:1]}
						: {2'b11, txShift_reg[9:1]};
					txBit_reg   <= txBit_reg - 4'h1;
					if (txBit_reg == 4'h1) txState_reg <= TX_IDLE;
				end
				default: txState_reg <= TX_IDLE;
				endcase
			end
		end
	end
	assign txLine = txLine_reg;
	wire txLoad = clkEn && modEn && txTick && txState_reg == TX_IDLE && !brkHold_reg &&
		!brkCtl && !preReq_reg && !queueIdle_reg && pendLoad_reg && ctrlB_reg[3];

	// receiver: sample mid-bit at baud_reg*8 /16 resolution kept simple
	logic [15:0] rxDiv_reg;
	logic [3:0]  rxBit_reg, onesCnt_reg;
	logic [9:0]  rxShift_reg;
	logic        rxActive_reg;
	wire rxEn = ctrlB_reg[`ASCS_B_RX_EN] && modEn;
	wire rxTick = rxDiv_reg == 16'h0000;
	logic rxDone, idleHit;
	always_ff @(posedge clock or negedge rs) begin
		if (!rs) begin
			rxDiv_reg    <= 16'h0000;
			rxBit_reg    <= 4'h0;
			rxShift_reg  <= 10'h000;
			rxActive_reg <= 1'b0;
			onesCnt_reg  <= 4'h0;
		end else if (clkEn) begin
			if (!rxEn) begin
				rxActive_reg <= 1'b0;
				onesCnt_reg  <= 4'h0;
			end else if (!rxActive_reg && !rxLine) begin
				rxActive_reg <= 1'b1;
				rxDiv_reg    <= {1'b0, baud_reg[15:1]};
				rxBit_reg    <= charLen;
				onesCnt_reg  <= 4'h0;
			end else if (rxActive_reg) begin
				rxDiv_reg <= rxTick ? baud_reg - 16'h0001 : rxDiv_reg - 16'h0001;
				if (rxTick) begin
					rxShift_reg <= {rxLine, rxShift_reg[9:1]};
					rxBit_reg   <= rxBit_reg - 4'h1;
					// frame ends on the stop bit sample
					if (rxBit_reg == 4'h1) rxActive_reg <= 1'b0;
				end
			end else begin
				rxDiv_reg <= rxTick ? baud_reg - 16'h0001 : rxDiv_reg - 16'h0001;
				if (rxTick && onesCnt_reg != charLen) onesCnt_reg <= onesCnt_reg + 4'h1;
			end
		end
	end
	assign rxDone  = clkEn && rxEn && rxActive_reg && rxTick && rxBit_reg == 4'h1;
	assign idleHit = clkEn && rxEn && !rxActive_reg && rxLine && rxTick &&
		onesCnt_reg == charLen - 4'h1;
	wire [8:0] rxWord = nine ? {rxShift_reg[9:1]} : {rxShift_reg[9], rxShift_reg[9:2]};
	wire rxMsb = nine ? rxWord[8] : rxWord[7];
	assign wakeHit = ctrlB_reg[`ASCS_B_STANDBY] && (ctrlA_reg[`ASCS_A_WAKE_ADDR] ?
		(rxDone && rxMsb) : idleHit);

	// status flags; hardware set wins over software clear
	always_ff @(posedge clock or negedge rs) begin
		if (!rs) begin
			status_reg   <= `ASCS_RST_STATUS;
			seenTxe_reg  <= 1'b0;
			seenRxf_reg  <= 1'b0;
			seenIdle_reg <= 1'b0;
			seenOvr_reg  <= 1'b0;
			idleArm_reg  <= 1'b0;
		end else if (clkEn) begin
			if (rdStat) begin
				seenTxe_reg  <= status_reg[`ASCS_S_TXE];
				seenRxf_reg  <= status_reg[`ASCS_S_RXF];
				seenIdle_reg <= status_reg[`ASCS_S_IDLE];
				seenOvr_reg  <= status_reg[`ASCS_S_OVR];
			end
			if (wrData && seenTxe_reg) begin
				status_reg[`ASCS_S_TXE] <= 1'b0;
				seenTxe_reg <= 1'b0;
			end
			if (rdData) begin
				if (seenRxf_reg) status_reg[`ASCS_S_RXF] <= 1'b0;
				if (seenIdle_reg) begin
					status_reg[`ASCS_S_IDLE] <= 1'b0;
					idleArm_reg <= 1'b0;
				end
				if (seenOvr_reg) status_reg[`ASCS_S_OVR] <= 1'b0;
				seenRxf_reg  <= 1'b0;
				seenIdle_reg <= 1'b0;
				seenOvr_reg  <= 1'b0;
			end
			if (txLoad) status_reg[`ASCS_S_TXE] <= 1'b1;
			// done drops when anything is queued (data only while TX is enabled), before shifting begins
			status_reg[`ASCS_S_TXD] <= status_reg[`ASCS_S_TXE] && !txBusy &&
				!preReq_reg && !queueIdle_reg && !brkHold_reg && !brkCtl &&
				!(pendLoad_reg && ctrlB_reg[3]);
			if (!rxEn) idleArm_reg <= 1'b0;
			if (rxDone) begin
				if (status_reg[`ASCS_S_RXF] && !(rdData && seenRxf_reg))
					status_reg[`ASCS_S_OVR] <= 1'b1;
				else begin
					status_reg[`ASCS_S_RXF] <= 1'b1;
					// stop bit is the sample taken on this very tick
					status_reg[`ASCS_S_FE]  <= !rxLine;
					idleArm_reg <= 1'b1;
				end
			end
			if (idleHit && idleArm_reg) status_reg[`ASCS_S_IDLE] <= 1'b1;
			if (!modEn) begin
				status_reg[`ASCS_S_TXE] <= 1'b1;
				status_reg[`ASCS_S_TXD] <= 1'b1;
			end
		end
	end

	// received data and ninth bit; untouched by reset
	always_ff @(posedge clock) begin
		if (clkEn && rxDone && !(status_reg[`ASCS_S_RXF] && !(rdData && seenRxf_reg))) begin
			rxData_reg <= rxWord[7:0];
			rx9_reg    <= nine ? rxWord[8] : rxWord[7];
		end
	end

	// interrupt requests
	always_comb begin
		irq_next.txReq = modEn && ((ctrlB_reg[`ASCS_B_TXE_IE] && status_reg[`ASCS_S_TXE]) ||
			(ctrlB_reg[`ASCS_B_TXD_IE] && status_reg[`ASCS_S_TXD]));
		irq_next.rxReq = !ctrlB_reg[`ASCS_B_STANDBY] &&
			((ctrlB_reg[`ASCS_B_RXF_IE] && status_reg[`ASCS_S_RXF]) ||
			(ctrlB_reg[`ASCS_B_IDLE_IE] && status_reg[`ASCS_S_IDLE]));
		irq_next.errReq = |(ctrlC_reg[3:0] & status_reg[3:0]);
	end
	always_ff @(posedge clock or negedge rs) begin
		if (!rs) begin
			txIrq  <= 1'b0;
			rxIrq  <= 1'b0;
			errIrq <= 1'b0;
		end else if (clkEn) begin
			txIrq  <= irq_next.txReq;
			rxIrq  <= irq_next.rxReq;
			errIrq <= irq_next.errReq;
		end
	end
endmodule // ascs_core
`default_nettype wire

/* tb/ascs_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ascs_core_properties (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        clkEn,
	input wire logic [3:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        txLine,
	input wire logic        rxLine,
	input wire logic        txIrq,
	input wire logic        rxIrq,
	input wire logic        errIrq
);
	// shadows of written enables; raw writes, so they can overstate what is enabled, and can understate it after ctrlB writes made while the module is off
	logic [7:0] shA_reg;
	logic [7:0] shB_reg;
	logic [7:0] shC_reg;
	logic       armed_reg;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			shA_reg   <= 8'h00;
			shB_reg   <= 8'h00;
			shC_reg   <= 8'h00;
			armed_reg <= 1'b0;
		end else if (write && !waitrequest) begin
			if (address == 4'h0)
				shA_reg <= writedata[7:0];
			if (address == 4'h1)
				shB_reg <= writedata[7:0];
			if (address == 4'h2)
				shC_reg <= writedata[7:0];
			if (address == 4'h1 && shA_reg[7] && (writedata[3] || writedata[0]))
				armed_reg <= 1'b1;
		end
	end
	// mirror of the core's two-stage reset release
	logic syncA_reg;
	logic syncB_reg;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			syncA_reg <= 1'b0;
			syncB_reg <= 1'b0;
		end else begin
			syncA_reg <= 1'b1;
			syncB_reg <= syncA_reg;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!syncB_reg);
	property p_ackNext; (read || write) && waitrequest && clkEn |=> !waitrequest; endproperty
	property p_ackOne; !waitrequest |=> waitrequest; endproperty
	property p_rdHold; !(read && waitrequest) |=> $stable(readdata); endproperty
	property p_unmapped; read && !waitrequest && address > 4'h5 |-> readdata == 32'h0000_0000; endproperty
	property p_rstIrq; $rose(syncB_reg) |-> !txIrq && !rxIrq && !errIrq; endproperty
	property p_txQuiet; shB_reg[7:6] == 2'b00 [*3] |-> !txIrq; endproperty
	property p_modOff; !shA_reg[7] [*3] |-> !txIrq; endproperty
	property p_rxQuiet; shB_reg[5:4] == 2'b00 [*3] |-> !rxIrq; endproperty
	property p_errQuiet; shC_reg[3:0] == 4'h0 [*3] |-> !errIrq; endproperty
	property p_txIdle; !armed_reg |-> txLine; endproperty
	a_ackNext: assert property (p_ackNext) else $error("no ack one cycle after request");
	a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
	a_rdHold: assert property (p_rdHold) else $error("read data changed without read");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_rstIrq: assert property (p_rstIrq) else $error("irq active after reset");
	a_txQuiet: assert property (p_txQuiet) else $error("tx irq without enable");
	a_modOff: assert property (p_modOff) else $error("tx irq while module off");
	a_rxQuiet: assert property (p_rxQuiet) else $error("rx irq without enable");
	a_errQuiet: assert property (p_errQuiet) else $error("error irq without enable");
	a_txIdle: assert property (p_txIdle) else $error("tx line active before tx enabled");
	c_rdAck: cover property (read && !waitrequest);
	c_rxIrq: cover property ($rose(rxIrq));
	c_errIrq: cover property ($rose(errIrq));
endmodule // ascs_core_properties
bind ascs_core ascs_core_properties i_ascs_core_properties (.clock(clock), .rstn(rstn),
	.clkEn(clkEn), .address(address), .read(read), .write(write), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest), .txLine(txLine), .rxLine(rxLine),
	.txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq));
`default_nettype wire

/* tb/ascs_remote_node.sv */
`timescale 1ns/1ps
`default_nettype none
module ascs_remote_node (
	input  wire logic clock,
	input  wire logic txLine,
	output var  logic rxLine
);
	localparam int BITCLK = 16;
	logic [8:0] gotQ[$];
	logic [8:0] sh;
	initial rxLine = 1'b1;
	// line idles high between frames, as a pulled-up serial wire does
	task automatic sendByte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clock);
			rxLine <= f[i];
			repeat (BITCLK - 1) @(posedge clock);
		end
	endtask
	// samples mid-bit; stop lands in sh[8], so a break shows a low stop
	initial begin
		forever begin
			@(negedge txLine);
			repeat (BITCLK / 2) @(posedge clock);
			for (int i = 0; i < 9; i++) begin
				repeat (BITCLK) @(posedge clock);
				sh[i] = txLine;
			end
			gotQ.push_back(sh);
		end
	end
endmodule // ascs_remote_node
`default_nettype wire

/* tb/async_serial_ctrl_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module async_serial_ctrl_status_bench;
	localparam int BITCLK = 16;
	logic        clock, rstn, clkEn, read, write, waitrequest, txLine, rxLine, txIrq, rxIrq, errIrq;
	logic [3:0]  address;
	logic [31:0] writedata, readdata;
	logic [7:0]  s, b1;
	logic [8:0]  got;
	logic [7:0]  expQ[$];
	int          n_mismatch = 0, n_compared = 0, cyc = 0, tEn;
	ascs_core i_ascs_core (.clock(clock), .rstn(rstn), .clkEn(clkEn), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .txLine(txLine), .rxLine(rxLine), .txIrq(txIrq),
		.rxIrq(rxIrq), .errIrq(errIrq));
	ascs_remote_node i_ascs_remote_node (.clock(clock), .txLine(txLine), .rxLine(rxLine));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;
	task chkVal(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task chkLvl(input logic g, input logic e);
		chkVal({7'h00, g}, {7'h00, e});
	endtask
	// holds the request until waitrequest is sampled low; data taken at that edge
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] w);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		writedata <= {24'h00_0000, w};
		write <= wr;
		read <= !wr;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) n_mismatch++;
		s = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic frame();
		for (int n = 0; n < 600 && i_ascs_remote_node.gotQ.size() == 0; n++) @(posedge clock);
		if (i_ascs_remote_node.gotQ.size() == 0) n_mismatch++;
		else got = i_ascs_remote_node.gotQ.pop_front();
	endtask
	task summarize;
		$display("mismatches=%0d compared=%0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		summarize();
	end
	initial begin
		// non-blocking so the reset edge is seen by every process
		rstn <= 1'b0;
		clkEn = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0000_0000;
		void'($urandom(83265));
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		xfer(0, 4'h3, 8'h00);
		chkVal(s, 8'hC0);
		xfer(0, 4'h1, 8'h00);
		chkVal(s, 8'h00);
		xfer(0, 4'h2, 8'h00);
		chkVal(s & 8'h7F, 8'h00);
		xfer(0, 4'hF, 8'h00);
		chkVal(s, 8'h00);
		xfer(1, 4'h1, 8'h08);
		xfer(0, 4'h1, 8'h00);
		chkLvl(s[3], 1'b0);
		xfer(1, 4'h0, 8'h80);
		xfer(1, 4'h1, 8'h88);
		tEn = cyc;
		repeat (3) @(posedge clock);
		chkLvl(txIrq, 1'b1);
		b1 = 8'($urandom);
		xfer(0, 4'h3, 8'h00);
		xfer(1, 4'h4, b1);
		for (int n = 0; n < 600 && txLine !== 1'b0; n++) @(posedge clock);
		chkLvl(cyc - tEn >= 10 * BITCLK, 1'b1);
		frame();
		chkVal(got[7:0], b1);
		chkLvl(got[8], 1'b1);
		repeat (2 * BITCLK) @(posedge clock);
		xfer(0, 4'h3, 8'h00);
		chkVal(s & 8'hC0, 8'hC0);
		xfer(1, 4'h1, 8'h89);
		xfer(1, 4'h1, 8'h88);
		frame();
		chkVal(got[7:0], 8'h00);
		chkLvl(got[8], 1'b0);
		xfer(1, 4'h1, 8'h24);
		xfer(1, 4'h2, 8'h08);
		expQ.push_back(8'($urandom));
		i_ascs_remote_node.sendByte(expQ[0]);
		for (int n = 0; n < 100 && rxIrq !== 1'b1; n++) @(posedge clock);
		chkLvl(rxIrq, 1'b1);
		xfer(0, 4'h3, 8'h00);
		chkVal(s & 8'h20, 8'h20);
		xfer(0, 4'h2, 8'h00);
		chkLvl(s[7], expQ[0][7]);
		xfer(0, 4'h4, 8'h00);
		chkVal(s, expQ.pop_front());
		xfer(0, 4'h3, 8'h00);
		chkVal(s & 8'h20, 8'h00);
		// second byte arrives unread: the model keeps the first, drops the next
		expQ.push_back(8'($urandom));
		i_ascs_remote_node.sendByte(expQ[0]);
		i_ascs_remote_node.sendByte(8'($urandom));
		repeat (12 * BITCLK) @(posedge clock);
		xfer(0, 4'h3, 8'h00);
		chkVal(s & 8'h38, 8'h38);
		chkLvl(errIrq, 1'b1);
		xfer(0, 4'h4, 8'h00);
		chkVal(s, expQ.pop_front());
		xfer(0, 4'h3, 8'h00);
		chkVal(s & 8'h38, 8'h00);
		xfer(1, 4'h1, 8'hC0);
		repeat (3) @(posedge clock);
		chkLvl(txIrq, 1'b1);
		// clock enable low: the held write must wait and the irq must not move
		clkEn <= 1'b0;
		fork
			xfer(1, 4'h0, 8'h00);
			begin
				repeat (6) @(posedge clock);
				chkLvl(waitrequest, 1'b1);
				chkLvl(txIrq, 1'b1);
				clkEn <= 1'b1;
			end
		join
		repeat (3) @(posedge clock);
		chkLvl(txIrq, 1'b0);
		summarize();
	end
endmodule // async_serial_ctrl_status_bench
`default_nettype wire
